// ==== hw/etci_map.svh ====
`ifndef ETCI_MAP_SVH
`define ETCI_MAP_SVH

// register byte offsets
`define ETCI_OFS_CHANNEL_ENABLE_VECTOR 12'h500
`define ETCI_OFS_SET 12'h504
`define ETCI_OFS_CLR 12'h508
`define ETCI_OFS_PTR_BASE 12'h510
`define ETCI_OFS_PTR_END 12'h560
`define ETCI_OFS_TEP_BASE 12'h514
`define ETCI_PTR_STRIDE 12'h008

// pointer slot fields inside (addr - base)
`define ETCI_PTR_IDX_MSB 6
`define ETCI_PTR_IDX_LSB 3
`define ETCI_PTR_TEP_BIT 2

// channel layout
`define ETCI_NUM_CFG 10
`define ETCI_NUM_FIXED 12
`define ETCI_FIXED_LSB 20
`define ETCI_IMPL_MASK 32'hFFF0_03FF

// reset values
`define ETCI_EN_RESET 32'h0000_0000
`define ETCI_PTR_RESET 32'h0000_0000
`define ETCI_RD_IDLE 32'h0000_0000

`endif

// ==== hw/etci_pkg.sv ====
package etci_pkg;

    // one bus word
    typedef logic [31:0] etci_word_t;

    // which register a bus address selects
    typedef enum logic [2:0] {
        etci_sel_none,
        etci_sel_channel_enable_vector,
        etci_sel_set,
        etci_sel_clr,
        etci_sel_eep,
        etci_sel_tep
    } etci_sel_t;

endpackage : etci_pkg

// ==== hw/etci_ptr_match.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "etci_map.svh"

// turns an endpoint address into a one-hot line select
module etci_ptr_match #(
    parameter int N = 32,
    parameter logic [31:0] BASE = 32'h4000_0000
) (
    // pointer under test
    input wire logic [31:0] ptr,
    // one-hot hit, all zero when the address is no endpoint
    output logic [N-1:0] hit
);

    // refuse sizes the compare cannot serve
    if (N < 1 || N > 1024) begin : g_bad_n
        $error("etci_ptr_match: N out of range");
    end

    // one comparator per endpoint, endpoints are word spaced
    for (genvar i = 0; i < N; i++) begin : g_hit
        localparam logic [31:0] ADDR = BASE + 32'(i * 4);
        assign hit[i] = (ptr == ADDR);
    end

endmodule : etci_ptr_match
`default_nettype wire

// ==== hw/etci_en_vec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "etci_map.svh"

// channel enable vector with direct, set and clear writes
module etci_en_vec (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // write strobes, at most one high
    input wire logic wr_channel_enable_vector,
    input wire logic wr_set,
    input wire logic wr_clr,
    input wire logic [31:0] wdata,
    // current enables
    output logic [31:0] en_q
);

    logic [31:0] en_d;
    logic [31:0] wmask;

    // only implemented channel bits can ever hold a one
    assign wmask = wdata & `ETCI_IMPL_MASK;

    // ones in the set alias set, ones in the clear alias clear
    always_comb begin
        en_d = en_q;
        if (wr_channel_enable_vector) begin
            en_d = wmask;
        end else if (wr_set) begin
            en_d = en_q | wmask;
        end else if (wr_clr) begin
            en_d = en_q & ~wmask;
        end
    end

    // all channels come up disabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_q <= `ETCI_EN_RESET;
        end else begin
            en_q <= en_d;
        end
    end

endmodule : etci_en_vec
`default_nettype wire

// ==== hw/etci_top.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "etci_map.svh"

module etci_top #(
    parameter int NUM_EVT = 32,
    parameter int NUM_TASK = 32,
    parameter logic [31:0] EVT_BASE = 32'h4000_0100,
    parameter logic [31:0] TASK_BASE = 32'h4000_0000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // event lines from peripherals, one-cycle pulses
    input wire logic [NUM_EVT-1:0] event_pulse,
    // task lines to peripherals, one-cycle pulses
    output logic [NUM_TASK-1:0] task_pulse_q,
    // hard-wired channels 20 to 31
    input wire logic [`ETCI_NUM_FIXED-1:0] fixed_evt,
    output logic [`ETCI_NUM_FIXED-1:0] fixed_task_q
);

    localparam int NCFG = `ETCI_NUM_CFG;

    // refuse endpoint counts the pointer decode cannot serve
    if (NUM_EVT < 1 || NUM_EVT > 1024 || NUM_TASK < 1 || NUM_TASK > 1024) begin : g_bad
        $error("etci_top: endpoint count out of range");
    end

    logic [31:0] en_q;
    logic [31:0] eep_q [NCFG];
    logic [31:0] tep_q [NCFG];
    logic [NCFG-1:0] fire;
    logic [NUM_TASK-1:0] task_acc [NCFG+1];

    // address decode
    wire [11:0] ptr_off;
    wire ptr_hit;
    wire [3:0] ptr_idx;
    wire ptr_tep;
    etci_pkg::etci_sel_t sel;

    assign ptr_off = reg_addr - `ETCI_OFS_PTR_BASE;
    assign ptr_hit = (reg_addr >= `ETCI_OFS_PTR_BASE) && (reg_addr < `ETCI_OFS_PTR_END)
        && (reg_addr[1:0] == 2'h0);
    assign ptr_idx = ptr_off[`ETCI_PTR_IDX_MSB:`ETCI_PTR_IDX_LSB];
    assign ptr_tep = ptr_off[`ETCI_PTR_TEP_BIT];

    // register select from the address
    always_comb begin
        if (reg_addr == `ETCI_OFS_CHANNEL_ENABLE_VECTOR) begin
            sel = etci_pkg::etci_sel_channel_enable_vector;
        end else if (reg_addr == `ETCI_OFS_SET) begin
            sel = etci_pkg::etci_sel_set;
        end else if (reg_addr == `ETCI_OFS_CLR) begin
            sel = etci_pkg::etci_sel_clr;
        end else if (ptr_hit && !ptr_tep) begin
            sel = etci_pkg::etci_sel_eep;
        end else if (ptr_hit) begin
            sel = etci_pkg::etci_sel_tep;
        end else begin
            sel = etci_pkg::etci_sel_none;
        end
    end

    // write strobes per register
    wire wr_channel_enable_vector;
    wire wr_set;
    wire wr_clr;
    wire wr_eep;
    wire wr_tep;
    assign wr_channel_enable_vector = reg_wr && (sel == etci_pkg::etci_sel_channel_enable_vector);
    assign wr_set = reg_wr && (sel == etci_pkg::etci_sel_set);
    assign wr_clr = reg_wr && (sel == etci_pkg::etci_sel_clr);
    assign wr_eep = reg_wr && (sel == etci_pkg::etci_sel_eep);
    assign wr_tep = reg_wr && (sel == etci_pkg::etci_sel_tep);

    // the written task address must name a task register
    logic [NUM_TASK-1:0] wtask_hit;
    wire tep_ok;

    etci_ptr_match #(
        .N(NUM_TASK),
        .BASE(TASK_BASE)
    ) u_wtask (
        .ptr(reg_wdata),
        .hit(wtask_hit)
    );

    assign tep_ok = |wtask_hit;

    // enable vector and its aliases
    etci_en_vec u_en (
        .core_clk(core_clk),
        .rst(rst),
        .wr_channel_enable_vector(wr_channel_enable_vector),
        .wr_set(wr_set),
        .wr_clr(wr_clr),
        .wdata(reg_wdata),
        .en_q(en_q)
    );

    assign task_acc[0] = '0;

    // per configurable channel: pointers, event pick and task drive
    for (genvar n = 0; n < NCFG; n++) begin : g_ch
        logic [NUM_EVT-1:0] evt_hit;
        logic [NUM_TASK-1:0] task_hit;

        etci_ptr_match #(
            .N(NUM_EVT),
            .BASE(EVT_BASE)
        ) u_evt (
            .ptr(eep_q[n]),
            .hit(evt_hit)
        );

        etci_ptr_match #(
            .N(NUM_TASK),
            .BASE(TASK_BASE)
        ) u_task (
            .ptr(tep_q[n]),
            .hit(task_hit)
        );

        // a channel fires only while enabled and its event pulses
        assign fire[n] = en_q[n] && |(evt_hit & event_pulse);
        assign task_acc[n+1] = task_acc[n] | (fire[n] ? task_hit : '0);

        // an enabled channel whose event pulses drives its named task line next cycle
        property p_ch_fwd;
            @(posedge core_clk) disable iff (rst)
                fire[n] |=> (task_pulse_q & $past(task_hit)) == $past(task_hit);
        endproperty
        a_ch_fwd: assert property (p_ch_fwd)
            else $error("enabled channel lost its task pulse");

        // event pointer, any value is stored as written
        always_ff @(posedge core_clk) begin
            if (rst) begin
                eep_q[n] <= `ETCI_PTR_RESET;
            end else if (wr_eep && ptr_idx == 4'(n)) begin
                eep_q[n] <= reg_wdata;
            end
        end

        // task pointer, writes of a non-task address are dropped
        always_ff @(posedge core_clk) begin
            if (rst) begin
                tep_q[n] <= `ETCI_PTR_RESET;
            end else if (wr_tep && tep_ok && ptr_idx == 4'(n)) begin
                tep_q[n] <= reg_wdata;
            end
        end
    end

    // read data selection
    wire [31:0] rd_ptr;
    wire [31:0] rd_data_d;
    assign rd_ptr = ptr_tep ? tep_q[ptr_idx] : eep_q[ptr_idx];
    assign rd_data_d = (sel == etci_pkg::etci_sel_channel_enable_vector) ? en_q
        : (sel == etci_pkg::etci_sel_set) ? en_q
        : (sel == etci_pkg::etci_sel_clr) ? en_q
        : (sel == etci_pkg::etci_sel_none) ? `ETCI_RD_IDLE
        : rd_ptr;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_q <= `ETCI_RD_IDLE;
        end else begin
            reg_rdata_q <= reg_rd ? rd_data_d : `ETCI_RD_IDLE;
        end
    end

    // task pulses, one cycle after the event
    always_ff @(posedge core_clk) begin
        if (rst) begin
            task_pulse_q <= '0;
            fixed_task_q <= '0;
        end else begin
            task_pulse_q <= task_acc[NCFG];
            fixed_task_q <= fixed_evt & en_q[31:`ETCI_FIXED_LSB];
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    localparam logic [31:0] IMPL = `ETCI_IMPL_MASK;

    property p_set_alias;
        wr_set |=> en_q == ($past(en_q) | ($past(reg_wdata) & IMPL));
    endproperty
    a_set_alias: assert property (p_set_alias)
        else $error("set alias write gave wrong enables");

    property p_clr_alias;
        wr_clr |=> en_q == ($past(en_q) & ~($past(reg_wdata) & IMPL));
    endproperty
    a_clr_alias: assert property (p_clr_alias)
        else $error("clear alias write gave wrong enables");

    property p_alias_read;
        reg_rd && (sel == etci_pkg::etci_sel_set || sel == etci_pkg::etci_sel_clr)
            |=> reg_rdata_q == $past(en_q);
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("alias read did not return enables");

    property p_gap_bits;
        (en_q & ~IMPL) == 32'h0000_0000;
    endproperty
    a_gap_bits: assert property (p_gap_bits)
        else $error("unimplemented enable bit set");

    // write step and read step of a pointer round trip
    sequence s_eep_wr;
        wr_eep;
    endsequence

    sequence s_ptr_rd;
        reg_rd;
    endsequence

    property p_eep_back;
        logic [31:0] v;
        logic [11:0] a;
        (s_eep_wr, v = reg_wdata, a = reg_addr) ##1 (s_ptr_rd and (reg_addr == a))
            |=> reg_rdata_q == v;
    endproperty
    a_eep_back: assert property (p_eep_back)
        else $error("event pointer readback mismatch");

    property p_tep_guard;
        wr_tep && !tep_ok |=> tep_q[$past(ptr_idx)] == $past(rd_ptr);
    endproperty
    a_tep_guard: assert property (p_tep_guard)
        else $error("non-task address entered a task pointer");

    // a task address written to a task pointer is kept as written
    property p_tep_keep;
        wr_tep && tep_ok |=> tep_q[$past(ptr_idx)] == $past(reg_wdata);
    endproperty
    a_tep_keep: assert property (p_tep_keep)
        else $error("task address not stored in task pointer");

    // read data stays idle in any cycle that follows no read strobe
    property p_rd_idle;
        !reg_rd |=> reg_rdata_q == `ETCI_RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");

    property p_fixed_fwd;
        fixed_evt[0] && en_q[`ETCI_FIXED_LSB] |=> fixed_task_q[0];
    endproperty
    a_fixed_fwd: assert property (p_fixed_fwd)
        else $error("enabled channel did not forward");

    property p_cfg_block;
        en_q[NCFG-1:0] == '0 |=> task_pulse_q == '0;
    endproperty
    a_cfg_block: assert property (p_cfg_block)
        else $error("disabled channels drove a task");

endmodule : etci_top
`default_nettype wire

// ==== tb/etci_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module etci_tb_top;
    localparam logic [31:0] EB = 32'h4000_0100;
    localparam logic [31:0] TB = 32'h4000_0000;

    // one table row: write address and data, expected enable vector after it
    typedef struct {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [31:0] ev;
    } etci_row_t;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_q;
    logic [31:0] event_pulse = 32'h0000_0000;
    logic [31:0] task_pulse_q;
    logic [11:0] fixed_evt = 12'h000;
    logic [11:0] fixed_task_q;
    int n_fail = 0;
    int total_checks = 0;
    etci_row_t rows [6];

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    etci_top #(.EVT_BASE(EB), .TASK_BASE(TB)) i_dut (
        .core_clk(core_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q),
        .event_pulse(event_pulse),
        .task_pulse_q(task_pulse_q),
        .fixed_evt(fixed_evt),
        .fixed_task_q(fixed_task_q)
    );

    // prints the counts and the verdict, then stops
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // compares one seen value against its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data sampled in the following cycle only
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask : rd

    // write followed by a read with no idle cycle between them
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [11:0] ra,
                         input logic [31:0] exp);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, exp);
        @(posedge core_clk);
        #1 chk(reg_rdata_q, 32'h0000_0000);
    endtask : wr_rd

    // one event cycle, then the task lines one and two cycles later
    task automatic pulse(input logic [31:0] ev, input logic [11:0] fe, input logic [31:0] te,
                         input logic [11:0] fte);
        @(posedge core_clk);
        event_pulse <= ev;
        fixed_evt <= fe;
        @(posedge core_clk);
        event_pulse <= 32'h0000_0000;
        fixed_evt <= 12'h000;
        #1 chk(task_pulse_q, te);
        chk({20'h0_0000, fixed_task_q}, {20'h0_0000, fte});
        @(posedge core_clk);
        #1 chk(task_pulse_q, 32'h0000_0000);
    endtask : pulse

    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        rows[0] = '{12'h504, 32'h0010_0001, 32'h0010_0001};
        rows[1] = '{12'h504, 32'h0000_0000, 32'h0010_0001};
        rows[2] = '{12'h504, 32'hFFFF_FFFF, 32'hFFF0_03FF};
        rows[3] = '{12'h508, 32'h0000_0201, 32'hFFF0_01FE};
        rows[4] = '{12'h508, 32'h0000_0000, 32'hFFF0_01FE};
        rows[5] = '{12'h508, 32'hFFFF_FFFF, 32'h0000_0000};
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        // reset values of vector, aliases and the channel 0 event pointer
        rd(12'h500, 32'h0000_0000);
        rd(12'h504, 32'h0000_0000);
        rd(12'h508, 32'h0000_0000);
        rd(12'h510, 32'h0000_0000);
        // table of alias writes, each read back through an alias
        foreach (rows[i]) begin
            wr_rd(rows[i].wa, rows[i].wd, (i % 2 == 0) ? 12'h504 : 12'h508, rows[i].ev);
        end
        // first and last event pointers hold full words
        wr_rd(12'h510, 32'hA5A5_5A5A, 12'h510, 32'hA5A5_5A5A);
        wr_rd(12'h558, 32'h1234_5678, 12'h558, 32'h1234_5678);
        // task pointer keeps a task address and refuses anything else
        wr_rd(12'h55C, TB + 32'h0000_007C, 12'h55C, TB + 32'h0000_007C);
        wr_rd(12'h55C, 32'h0000_0123, 12'h55C, TB + 32'h0000_007C);
        // unmapped place reads zero
        wr_rd(12'h600, 32'hFFFF_FFFF, 12'h600, 32'h0000_0000);
        // channel 2 routes event 5 to task 7 once enabled
        wr(12'h520, EB + 32'h0000_0014);
        wr(12'h524, TB + 32'h0000_001C);
        pulse(32'h0000_0020, 12'h000, 32'h0000_0000, 12'h000);
        wr(12'h504, 32'h0010_0004);
        pulse(32'h0000_0020, 12'h003, 32'h0000_0080, 12'h001);
        pulse(32'hFFFF_FFDF, 12'h000, 32'h0000_0000, 12'h000);
        wr(12'h508, 32'h0000_0004);
        pulse(32'h0000_0020, 12'h001, 32'h0000_0000, 12'h001);
        // reset in mid-run clears every enable
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(12'h504, 32'h0000_0000);
        pulse(32'h0000_0000, 12'h001, 32'h0000_0000, 12'h000);
        end_sim();
    end
endmodule : etci_tb_top

`default_nettype wire
